// ==== rtl/gpio_ports.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpio_ports
  import gpio_pkg::*;
(
  input  wire logic              sys_clk_i,                   // 125 MHz clock
  input  wire logic              rst_n_i,                     // Power-on reset
  input  wire logic              soft_rst_i,                  // Other reset
  input  wire logic [ADDR_W-1:0] addr_i,                      // Register address
  input  wire logic [DATA_W-1:0] wdata_i,                     // Write data
  input  wire logic              wr_i,                        // Write strobe
  input  wire logic              rd_i,                        // Read strobe
  output logic      [DATA_W-1:0] rdata_o,                     // Read data
  input  wire logic [PA_W-1:0]   first_port_pins_i,           // First port pins
  output logic      [PA_W-1:0]   first_port_pins_o,           // First port drive
  output logic      [PA_W-1:0]   first_port_oe_o,             // First port enable
  input  wire logic [PB_W-1:0]   second_port_pins_i,          // Second port pins
  output logic      [PB_W-1:0]   second_port_pins_o,          // Second port drive
  output logic      [PB_W-1:0]   second_port_oe_o,            // Second port enable
  output logic      [PB_W-1:0]   second_port_pullup_o,        // Weak pull-up on
  output logic                   timer_external_clock_in_o,   // Timer clock level
  output logic                   port_change_irq_o,           // Change interrupt
  output logic                   wake_o                       // Sleep wake request
);

  // Address match used for read and write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  // Control register address match, both banks
  function automatic logic is_intc(input logic [ADDR_W-1:0] a);
    is_intc = hit(a, ADDR_INTC_LO) || hit(a, ADDR_INTC_HI);
  endfunction

  state_t   st_reg;
  state_t   st_next;
  bus_req_t req;

  assign req.addr  = addr_i;
  assign req.wdata = wdata_i;
  assign req.wr    = wr_i;
  assign req.rd    = rd_i;

  // Next-state logic for the whole block
  always_comb begin
    logic             pb_acc;
    logic [MON_W-1:0] mon_dir;
    logic [MON_W-1:0] mon_pin;
    logic [MON_W-1:0] mismatch;
    logic             change;
    logic [DATA_W-1:0] rd_val;
    pb_acc   = 1'b0;
    mon_dir  = MON_ZERO;
    mon_pin  = MON_ZERO;
    mismatch = MON_ZERO;
    change   = 1'b0;
    rd_val   = ZERO_BYTE;
    st_next  = st_reg;

    // Two-stage synchronisers on all pins
    st_next.pa_s1 = first_port_pins_i;
    st_next.pa_s2 = st_reg.pa_s1;
    st_next.pb_s1 = second_port_pins_i;
    st_next.pb_s2 = st_reg.pb_s1;

    pb_acc = (req.rd || req.wr) && hit(req.addr, ADDR_PB_DATA);

    // Register writes; latch takes the CPU's modified pin value
    if (req.wr) begin
      if (hit(req.addr, ADDR_PA_DATA)) begin
        st_next.pa_lat = req.wdata[PA_W-1:0];
      end
      if (hit(req.addr, ADDR_PA_DIR)) begin
        st_next.pa_dir = req.wdata[PA_W-1:0];
      end
      if (hit(req.addr, ADDR_PB_DATA)) begin
        st_next.pb_lat = req.wdata;
      end
      if (hit(req.addr, ADDR_PB_DIR)) begin
        st_next.pb_dir = req.wdata;
      end
      if (hit(req.addr, ADDR_OPTION)) begin
        st_next.option = req.wdata;
      end
      if (is_intc(req.addr)) begin
        st_next.intc = req.wdata;
        st_next.intc[INTC_RSV_BIT] = 1'b0;
      end
    end

    // Any second-port data register access refreshes the compare copy
    if (pb_acc) begin
      st_next.snap = st_reg.pb_s2[MON_LSB +: MON_W];
    end

    // Mismatch on monitored input pins only
    mon_dir  = st_reg.pb_dir[MON_LSB +: MON_W];
    mon_pin  = st_reg.pb_s2[MON_LSB +: MON_W];
    mismatch = (mon_pin ^ st_reg.snap) & mon_dir;
    change   = (|mismatch) && !pb_acc;

    // Flag set wins over a software clear, enables ignored
    if (change) begin
      st_next.intc[INTC_FLAG_BIT] = 1'b1;
    end

    // Other reset: directions and option to ones, latches kept
    if (soft_rst_i) begin
      st_next.pa_dir = PA_DIR_RST;
      st_next.pb_dir = PB_DIR_RST;
      st_next.option = OPTION_RST;
      st_next.intc   = {st_reg.intc[INTC_GIE_BIT],
                        INTC_RST[DATA_W-2:1],
                        st_next.intc[INTC_FLAG_BIT]};
    end

    // Pin drivers; open-drain bit only ever pulls low
    st_next.pa_out = st_next.pa_lat;
    st_next.pa_oe  = ~st_next.pa_dir;
    st_next.pa_out[OD_BIT] = 1'b0;
    st_next.pa_oe[OD_BIT]  = ~st_next.pa_dir[OD_BIT]
                             & ~st_next.pa_lat[OD_BIT];
    st_next.pb_out = st_next.pb_lat;
    st_next.pb_oe  = ~st_next.pb_dir;

    // Global pull-up enable, forced off on outputs
    st_next.pb_pu = st_next.option[OPT_PU_N_BIT] ? ZERO_BYTE
                    : st_next.pb_dir;

    // Timer clock taken from the synchronised open-drain pin
    st_next.tmr_clk = st_reg.pa_s2[OD_BIT];

    // Interrupt and wake request from flag and enable
    st_next.irq  = st_next.intc[INTC_FLAG_BIT]
                   & st_next.intc[INTC_PORT_CHANGE_IRQ_ENABLE_BIT];
    st_next.wake = st_next.intc[INTC_FLAG_BIT]
                   & st_next.intc[INTC_PORT_CHANGE_IRQ_ENABLE_BIT];

    // Read mux; unmapped addresses and bits return zero
    if (req.rd) begin
      if (hit(req.addr, ADDR_PA_DATA)) begin
        rd_val = {3'h0, st_reg.pa_s2};
      end else if (hit(req.addr, ADDR_PA_DIR)) begin
        rd_val = {3'h0, st_reg.pa_dir};
      end else if (hit(req.addr, ADDR_PB_DATA)) begin
        rd_val = st_reg.pb_s2;
      end else if (hit(req.addr, ADDR_PB_DIR)) begin
        rd_val = st_reg.pb_dir;
      end else if (hit(req.addr, ADDR_OPTION)) begin
        rd_val = st_reg.option;
      end else if (is_intc(req.addr)) begin
        rd_val = st_reg.intc;
      end else begin
        rd_val = ZERO_BYTE;
      end
    end
    st_next.rdata = rd_val;
  end

  // State register; power-on reset loads constants only
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg         <= '0;
      st_reg.pa_lat  <= PA_LAT_RST;
      st_reg.pb_lat  <= PB_LAT_RST;
      st_reg.pa_dir  <= PA_DIR_RST;
      st_reg.pb_dir  <= PB_DIR_RST;
      st_reg.option  <= OPTION_RST;
      st_reg.intc    <= INTC_RST;
      st_reg.snap    <= MON_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign rdata_o                   = st_reg.rdata;
  assign first_port_pins_o         = st_reg.pa_out;
  assign first_port_oe_o           = st_reg.pa_oe;
  assign second_port_pins_o        = st_reg.pb_out;
  assign second_port_oe_o          = st_reg.pb_oe;
  assign second_port_pullup_o      = st_reg.pb_pu;
  assign timer_external_clock_in_o = st_reg.tmr_clk;
  assign port_change_irq_o         = st_reg.irq;
  assign wake_o                    = st_reg.wake;

endmodule
`default_nettype wire

// ==== shared/gpio_pkg.sv ====
package gpio_pkg;

  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PA_W   = 5;
  localparam int PB_W   = 8;
  localparam int MON_W  = 4;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_PA_DATA = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_PA_DIR  = 8'h85;
  localparam logic [ADDR_W-1:0] ADDR_PB_DATA = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_PB_DIR  = 8'h86;
  localparam logic [ADDR_W-1:0] ADDR_OPTION  = 8'h81;
  localparam logic [ADDR_W-1:0] ADDR_INTC_LO = 8'h0B;
  localparam logic [ADDR_W-1:0] ADDR_INTC_HI = 8'h8B;

  // Field positions
  localparam int OPT_PU_N_BIT  = 7;
  localparam int INTC_GIE_BIT  = 7;
  localparam int INTC_RSV_BIT  = 6;
  localparam int INTC_PORT_CHANGE_IRQ_ENABLE_BIT = 3;
  localparam int INTC_FLAG_BIT = 0;
  localparam int OD_BIT        = 4;
  localparam int MON_LSB       = 4;

  // Reset values
  localparam logic [PA_W-1:0]   PA_DIR_RST = 5'h1F;
  localparam logic [PB_W-1:0]   PB_DIR_RST = 8'hFF;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
  localparam logic [DATA_W-1:0] INTC_RST   = 8'h00;
  localparam logic [PA_W-1:0]   PA_LAT_RST = 5'h00;
  localparam logic [PB_W-1:0]   PB_LAT_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [MON_W-1:0]  MON_ZERO   = 4'h0;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  // Whole state of the block
  typedef struct packed {
    logic [PA_W-1:0]   pa_s1;
    logic [PA_W-1:0]   pa_s2;
    logic [PB_W-1:0]   pb_s1;
    logic [PB_W-1:0]   pb_s2;
    logic [PA_W-1:0]   pa_lat;
    logic [PA_W-1:0]   pa_dir;
    logic [PB_W-1:0]   pb_lat;
    logic [PB_W-1:0]   pb_dir;
    logic [DATA_W-1:0] option;
    logic [DATA_W-1:0] intc;
    logic [MON_W-1:0]  snap;
    logic [PA_W-1:0]   pa_out;
    logic [PA_W-1:0]   pa_oe;
    logic [PB_W-1:0]   pb_out;
    logic [PB_W-1:0]   pb_oe;
    logic [PB_W-1:0]   pb_pu;
    logic              tmr_clk;
    logic              irq;
    logic              wake;
    logic [DATA_W-1:0] rdata;
  } state_t;

endpackage

// ==== test/gpio_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpio_chk
  import gpio_pkg::*;
(
  input wire logic       sys_clk_i,            // Clock
  input wire logic       rst_n_i,              // Reset
  input wire logic       soft_rst_i,           // Soft reset
  input wire logic [7:0] addr_i,               // Address
  input wire logic [7:0] wdata_i,              // Data
  input wire logic       wr_i,                 // Write
  input wire logic       rd_i,                 // Read
  input wire logic [7:0] rdata_o,              // Read data
  input wire logic [4:0] first_port_pins_o,    // Drive
  input wire logic [4:0] first_port_oe_o,      // Enable
  input wire logic [7:0] second_port_pins_o,   // Drive
  input wire logic [7:0] second_port_oe_o,     // Enable
  input wire logic [7:0] second_port_pullup_o, // Pull-up
  input wire logic       port_change_irq_o,    // Irq
  input wire logic       wake_o                // Wake
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A register write followed by a quiet bus cycle
  sequence s_wr_quiet(a);
    wr_i && addr_i == a && !soft_rst_i ##1 !wr_i && !soft_rst_i;
  endsequence
  a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not cleared");
  a_pa_upper: assert property (rd_i && addr_i == ADDR_PA_DATA |=> rdata_o[7:5] == 3'h0)
    else $error("upper first port bits set");
  a_unmapped: assert property (rd_i && addr_i == 8'h07 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_pb_latch: assert property (s_wr_quiet(ADDR_PB_DATA) |=>
    second_port_pins_o == $past(wdata_i, 2)) else $error("second latch not written");
  a_pb_dir: assert property (s_wr_quiet(ADDR_PB_DIR) |=>
    second_port_oe_o == ~$past(wdata_i, 2)) else $error("second enable wrong");
  a_pu_off: assert property ((second_port_pullup_o & second_port_oe_o) == 8'h00)
    else $error("pull-up on an output");
  a_soft_dir: assert property (soft_rst_i ##1 !wr_i |=>
    first_port_oe_o == 5'h00 && second_port_oe_o == 8'h00) else $error("drivers after reset");
  a_od_low: assert property (!first_port_pins_o[OD_BIT]) else $error("open drain high");
  a_wake_irq: assert property (wake_o == port_change_irq_o) else $error("wake not irq");
endmodule
bind gpio_ports gpio_chk gpio_chk_i (.sys_clk_i, .rst_n_i, .soft_rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .first_port_pins_o, .first_port_oe_o, .second_port_pins_o,
  .second_port_oe_o, .second_port_pullup_o, .port_change_irq_o, .wake_o);
`default_nettype wire

// ==== test/pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_model #(
  parameter int W = 8
) (
  input  wire logic         clk_i,    // Clock
  input  wire logic [W-1:0] out_i,    // Drive value
  input  wire logic [W-1:0] oe_i,     // Drive enable
  input  wire logic [W-1:0] pu_i,     // Pull-up on
  input  wire logic [W-1:0] ext_i,    // Board level
  input  wire logic [W-1:0] ext_en_i, // Board drives
  output logic      [W-1:0] pin_o     // Wire level
);
  logic [W-1:0] flt_reg = '0;
  // Undriven lines without pull-up flip every cycle so a stale level is never seen
  always @(posedge clk_i) begin
    flt_reg <= ~flt_reg;
  end
  // Device drive, then board drive, then weak pull-up
  assign pin_o = oe_i & out_i | ~oe_i & (ext_en_i & ext_i | ~ext_en_i & (pu_i | flt_reg));
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpio_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, srst = 1'b0, wr = 1'b0, rd = 1'b0, tmr, irq, wake;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rnd = 8'h59, pb_ext = 8'h00, pb_en = 8'hff;
  logic [7:0] pb_out, pb_oe, pb_pu, pb_pin;
  logic [4:0] pa_ext = 5'h00, pa_out, pa_oe, pa_pin, eoe;
  logic [7:0] m [5];
  logic [7:0] adr [5] = '{ADDR_PA_DIR, ADDR_PA_DATA, ADDR_PB_DIR, ADDR_PB_DATA, ADDR_OPTION};
  int         num_errors = 0, checks_done = 0;
  // Clock at 125 MHz
  initial forever #4 clk = ~clk;
  gpio_ports gpio_ports_i (.sys_clk_i(clk), .rst_n_i(rst_n), .soft_rst_i(srst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .first_port_pins_i(pa_pin),
    .first_port_pins_o(pa_out), .first_port_oe_o(pa_oe), .second_port_pins_i(pb_pin),
    .second_port_pins_o(pb_out), .second_port_oe_o(pb_oe), .second_port_pullup_o(pb_pu),
    .timer_external_clock_in_o(tmr), .port_change_irq_o(irq), .wake_o(wake));
  pin_model #(.W(5)) pa_model (.clk_i(clk), .out_i(pa_out), .oe_i(pa_oe), .pu_i(5'h00),
    .ext_i(pa_ext), .ext_en_i(5'h1f), .pin_o(pa_pin));
  pin_model pb_model (.clk_i(clk), .out_i(pb_out), .oe_i(pb_oe), .pu_i(pb_pu),
    .ext_i(pb_ext), .ext_en_i(pb_en), .pin_o(pb_pin));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // New board level, then time for the synchroniser and flag
  // Board changes only between accesses, never under a polling loop
  task automatic settle_pb(input logic [7:0] v);
    @(posedge clk);
    pb_ext <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Cut a hang short well after the expected run
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(ADDR_PA_DIR, 8'h1f);
    bus_rd(ADDR_OPTION, 8'hff);
    chk("pullup", 8'h00, pb_pu);
    bus_wr(8'h07, 8'hff);
    bus_rd(8'h07, 8'h00);
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 5; k++) begin
        rnd = lfsr(rnd);
        m[k] = rnd;
        bus_wr(adr[k], rnd);
      end
      @(posedge clk);
      pa_ext <= rnd[7:3];
      settle_pb(lfsr(rnd));
      eoe = {~m[0][4] & ~m[1][4], ~m[0][3:0]};
      chk("pa_oe", {3'h0, eoe}, {3'h0, pa_oe});
      chk("pa_out", {4'h0, m[1][3:0]}, {3'h0, pa_out});
      chk("pb_oe", ~m[2], pb_oe);
      chk("pb_out", m[3], pb_out);
      chk("pullup", m[4][7] ? 8'h00 : m[2], pb_pu);
      chk("timer", {7'h0, ~eoe[4] & pa_ext[4]}, {7'h0, tmr});
      bus_rd(ADDR_PA_DATA, {3'h0, eoe & m[1][4:0] | ~eoe & pa_ext});
      bus_rd(ADDR_PB_DATA, ~m[2] & m[3] | m[2] & pb_ext);
    end
    bus_wr(ADDR_PB_DIR, 8'hf0);
    settle_pb(8'h00);
    bus_rd(ADDR_PB_DATA, {4'h0, m[3][3:0]});
    bus_wr(ADDR_INTC_LO, 8'h08);
    settle_pb(8'h20);
    bus_rd(ADDR_INTC_HI, 8'h09);
    chk("irq", 8'h03, {6'h0, irq, wake});
    bus_wr(ADDR_INTC_LO, 8'h08);
    bus_rd(ADDR_INTC_LO, 8'h09);
    bus_rd(ADDR_PB_DATA, {4'h2, m[3][3:0]});
    bus_wr(ADDR_INTC_LO, 8'h08);
    bus_rd(ADDR_INTC_LO, 8'h08);
    bus_wr(ADDR_PB_DIR, 8'h70);
    bus_wr(ADDR_PB_DATA, 8'h00);
    bus_wr(ADDR_PB_DATA, 8'h80);
    settle_pb(8'h20);
    bus_rd(ADDR_INTC_LO, 8'h08);
    bus_wr(ADDR_INTC_LO, 8'h00);
    settle_pb(8'h60);
    bus_rd(ADDR_INTC_LO, 8'h01);
    chk("irq", 8'h00, {6'h0, irq, wake});
    bus_wr(ADDR_PB_DIR, 8'hff);
    bus_wr(ADDR_OPTION, 8'h00);
    pb_en <= 8'h00;
    settle_pb(8'h00);
    bus_rd(ADDR_PB_DATA, 8'hff);
    bus_wr(ADDR_PA_DIR, 8'h00);
    bus_wr(ADDR_PB_DIR, 8'h00);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    bus_rd(ADDR_PB_DIR, 8'hff);
    bus_rd(ADDR_PA_DIR, 8'h1f);
    chk("pb_out", 8'h80, pb_out);
    give_verdict();
  end
endmodule
`default_nettype wire
